// ---- pkg/css_pkg.sv ----
/*
 * Shared constants and types of the clock source select and start-up block.
 * Assumes fuse bits read one when unprogrammed and zero when programmed.
 */
package css_pkg;

	// ==========================================================
	// fuse encodings
	localparam logic [3:0] SEL_XTAL_MIN   = 4'hA;
	localparam logic [3:0] SEL_LFXTAL     = 4'h9;
	localparam logic [3:0] SEL_EXTRC_MIN  = 4'h5;
	localparam logic [3:0] SEL_INTRC_MIN  = 4'h1;
	localparam logic [3:0] SEL_EXTCLK     = 4'h0;
	localparam logic [3:0] SHIP_SEL       = 4'h1;
	localparam logic [1:0] SHIP_SUT       = 2'h2;
	localparam logic       FUSE_PROGRAMMED = 1'b0;

	// ==========================================================
	// start-up counts below the parameter threshold
	localparam int CK_6_CYC      = 6;
	localparam int CK_18_CYC     = 18;
	localparam int CK_258_CYC    = 258;
	localparam int CK_1K_CYC     = 1024;
	localparam int WDT_SHORT_CYC = 4096;

	// ==========================================================
	// register map, byte addresses
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_COUNT  = 4'h8;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_SLEEP    = 2;
	localparam int CTRL_ASYNC    = 3;
	localparam logic [1:0] MODE_IDLE   = 2'h0;
	localparam logic [1:0] MODE_ADCNR  = 2'h1;
	localparam logic [1:0] MODE_PDOWN  = 2'h2;
	localparam logic [1:0] MODE_PSAVE  = 2'h3;

	// ==========================================================
	// types
	typedef enum logic [2:0] {SRC_XTAL, SRC_LFXTAL, SRC_EXTRC, SRC_INTRC,
		SRC_EXTCLK} css_src_t;
	typedef enum logic [2:0] {RNG_NA, RNG_LOW, RNG_MID, RNG_HIGH,
		RNG_WIDE} css_range_t;
	typedef enum logic [2:0] {SU_6, SU_18, SU_258, SU_1K, SU_16K,
		SU_32K} css_su_t;
	typedef enum logic [1:0] {DLY_NONE, DLY_SHORT, DLY_LONG} css_dly_t;
	typedef enum logic [2:0] {ST_FUSE, ST_LOAD_RST, ST_RST_DLY, ST_SRC_START,
		ST_RUN, ST_SLEEP} css_state_t;

endpackage

// ---- rtl/css_fuse_decode.sv ----
/*
 * Decodes the fuse fields into source class, range, start-up count and
 * reset delay selections.
 * Assumes fuse values are held stable by the caller.
 */
`timescale 1ns/1ps
module css_fuse_decode
	import css_pkg::*;
(
	input  wire logic [3:0] sel_i,
	input  wire logic [1:0] sut_i,
	input  wire logic       swing_i,
	output css_src_t        src_o,
	output css_range_t      range_o,
	output css_su_t         su_o,
	output css_dly_t        dly_o,
	output logic            full_swing_o
);
	// ==========================================================
	// decode
	always_comb begin
		full_swing_o = (swing_i == FUSE_PROGRAMMED);
		range_o = RNG_NA;
		su_o = SU_6;
		dly_o = DLY_LONG;
		if (sel_i >= SEL_XTAL_MIN) begin
			src_o = SRC_XTAL;
			if (full_swing_o) begin
				range_o = RNG_WIDE;
			end else begin
				unique case (sel_i[3:1])
					3'h5: range_o = RNG_LOW;
					3'h6: range_o = RNG_MID;
					default: range_o = RNG_HIGH;
				endcase
			end
			unique case ({sel_i[0], sut_i})
				3'h0: begin su_o = SU_258; dly_o = DLY_SHORT; end
				3'h1: begin su_o = SU_258; dly_o = DLY_LONG; end
				3'h2: begin su_o = SU_1K; dly_o = DLY_NONE; end
				3'h3: begin su_o = SU_1K; dly_o = DLY_SHORT; end
				3'h4: begin su_o = SU_1K; dly_o = DLY_LONG; end
				3'h5: begin su_o = SU_16K; dly_o = DLY_NONE; end
				3'h6: begin su_o = SU_16K; dly_o = DLY_SHORT; end
				default: begin su_o = SU_16K; dly_o = DLY_LONG; end
			endcase
		end else if (sel_i == SEL_LFXTAL) begin
			src_o = SRC_LFXTAL;
			// reserved 11 falls back to the slowest, safest start
			su_o = (sut_i[1]) ? SU_32K : SU_1K;
			dly_o = (sut_i == 2'h0) ? DLY_SHORT : DLY_LONG;
		end else if (sel_i >= SEL_EXTRC_MIN) begin
			src_o = SRC_EXTRC;
			su_o = (sut_i == 2'h3) ? SU_6 : SU_18;
			unique case (sut_i)
				2'h0: dly_o = DLY_NONE;
				2'h2: dly_o = DLY_LONG;
				default: dly_o = DLY_SHORT;
			endcase
		end else begin
			src_o = (sel_i >= SEL_INTRC_MIN) ? SRC_INTRC : SRC_EXTCLK;
			unique case (sut_i)
				2'h0: dly_o = DLY_NONE;
				2'h1: dly_o = DLY_SHORT;
				default: dly_o = DLY_LONG;
			endcase
		end
	end

endmodule // css_fuse_decode

// ---- rtl/css_tick_count.sv ----
/*
 * Loadable down counter that steps on a tick pulse and flags zero.
 * Assumes tick pulses are one clock wide and synchronous.
 */
`timescale 1ns/1ps
module css_tick_count #(
	parameter int W = 17
) (
	input  wire logic         clk_sys_i,
	input  wire logic         reset_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] load_val_i,
	input  wire logic         tick_i,
	output logic [W-1:0]      count_o,
	output logic              done_o
);
	logic [W-1:0] cnt_ff;
	logic [W-1:0] nxt_cnt;

	// ==========================================================
	// count
	always_comb begin
		nxt_cnt = cnt_ff;
		if (load_i) begin
			nxt_cnt = load_val_i;
		end else if (tick_i && cnt_ff != '0) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_ff <= '0;
		end else begin
			cnt_ff <= nxt_cnt;
		end
	end

	assign count_o = cnt_ff;
	assign done_o = (cnt_ff == '0);

	step_down_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!load_i && tick_i && cnt_ff != '0 |=> cnt_ff + 1'b1 == $past(cnt_ff))
		else $error("counter did not step down on tick");

endmodule // css_tick_count

// ---- rtl/css_clock_ctrl.sv ----
/*
 * Clock source selection, start-up sequencing and clock domain gating,
 * with an Avalon-MM register slave.
 * Assumes tick inputs are one-cycle pulses, one per oscillator cycle, and
 * that the gate enables drive glitch-free clock gates outside this block.
 */
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module css_clock_ctrl
	import css_pkg::*;
#(
	parameter int CNT_W        = 17,
	parameter int CK_16K_CYC   = 16384,
	parameter int CK_32K_CYC   = 32768,
	parameter int WDT_LONG_CYC = 65536
) (
	input  wire logic        clk_sys_i,
	input  wire logic        reset_i,
	input  wire logic        fuse_loaded_i,
	input  wire logic [3:0]  clock_source_select_i,
	input  wire logic [1:0]  startup_time_select_i,
	input  wire logic        oscillator_swing_option_i,
	input  wire logic        src_tick_i,
	input  wire logic        wdt_tick_i,
	input  wire logic        wake_i,
	input  wire logic [3:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [31:0] avs_writedata_i,
	input  wire logic [3:0]  avs_byteenable_i,
	output logic [31:0]      avs_readdata_o,
	output logic             avs_waitrequest_o,
	output logic             core_clock_en_o,
	output logic             peripheral_clock_en_o,
	output logic             program_memory_clock_en_o,
	output logic             async_timer_clock_en_o,
	output logic             converter_clock_en_o,
	output logic             full_swing_o,
	output logic [2:0]       xtal_range_o
);
	// ==========================================================
	// elaboration checks
	if (CNT_W < 2 || CNT_W > 31) begin : g_bad_w
		$error("CNT_W out of range");
	end
	if (WDT_LONG_CYC >= (1 << CNT_W) || CK_32K_CYC >= (1 << CNT_W) ||
		CK_16K_CYC >= (1 << CNT_W) || WDT_SHORT_CYC >= (1 << CNT_W))
	begin : g_bad_cnt
		$error("counts do not fit CNT_W");
	end

	// ==========================================================
	// declarations
	logic [3:0]       sel_ff, nxt_sel;
	logic [1:0]       sut_ff, nxt_sut;
	logic             swing_ff, nxt_swing;
	css_state_t       state_ff, nxt_state;
	logic             cnt_load;
	logic [CNT_W-1:0] cnt_val;
	logic             cnt_tick;
	logic [CNT_W-1:0] cnt_q;
	logic             cnt_done;
	css_src_t         dec_src;
	css_range_t       dec_range;
	css_su_t          dec_su;
	css_dly_t         dec_dly;
	logic             dec_full;
	logic             wait_ff, nxt_wait;
	logic [31:0]      rdata_ff, nxt_rdata;
	logic [1:0]       mode_ff, nxt_mode;
	logic             req_ff, nxt_req;
	logic             async_en_ff, nxt_async_en;
	logic             wr_take;
	logic             core_ff, nxt_core;
	logic             periph_ff, nxt_periph;
	logic             async_ff, nxt_async;
	logic             conv_ff, nxt_conv;
	logic             full_ff;
	logic [2:0]       range_ff;
	logic [CNT_W-1:0] su_cyc;
	logic [CNT_W-1:0] dly_cyc;
	logic             deep_mode;

	// ==========================================================
	// fuse capture and decode
	always_comb begin
		nxt_sel = sel_ff;
		nxt_sut = sut_ff;
		nxt_swing = swing_ff;
		if (state_ff == ST_FUSE) begin
			// a blank fuse array means the factory setting applies
			nxt_sel = fuse_loaded_i ? clock_source_select_i : SHIP_SEL;
			nxt_sut = fuse_loaded_i ? startup_time_select_i : SHIP_SUT;
			nxt_swing = fuse_loaded_i ? oscillator_swing_option_i : 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			sel_ff <= SHIP_SEL;
			sut_ff <= SHIP_SUT;
			swing_ff <= 1'b1;
		end else begin
			sel_ff <= nxt_sel;
			sut_ff <= nxt_sut;
			swing_ff <= nxt_swing;
		end
	end

	css_fuse_decode u_dec (
		.sel_i        (sel_ff),
		.sut_i        (sut_ff),
		.swing_i      (swing_ff),
		.src_o        (dec_src),
		.range_o      (dec_range),
		.su_o         (dec_su),
		.dly_o        (dec_dly),
		.full_swing_o (dec_full)
	);

	// ==========================================================
	// count selection
	always_comb begin
		unique case (dec_su)
			SU_6:   su_cyc = CNT_W'(CK_6_CYC);
			SU_18:  su_cyc = CNT_W'(CK_18_CYC);
			SU_258: su_cyc = CNT_W'(CK_258_CYC);
			SU_1K:  su_cyc = CNT_W'(CK_1K_CYC);
			SU_16K: su_cyc = CNT_W'(CK_16K_CYC);
			SU_32K: su_cyc = CNT_W'(CK_32K_CYC);
			default: su_cyc = CNT_W'(CK_32K_CYC);
		endcase
		unique case (dec_dly)
			DLY_NONE:  dly_cyc = '0;
			DLY_SHORT: dly_cyc = CNT_W'(WDT_SHORT_CYC);
			DLY_LONG:  dly_cyc = CNT_W'(WDT_LONG_CYC);
			default:   dly_cyc = CNT_W'(WDT_LONG_CYC);
		endcase
	end

	// reset delay runs on the watchdog oscillator, everything else on source
	assign cnt_tick = (state_ff == ST_RST_DLY) ? wdt_tick_i : src_tick_i;
	assign deep_mode = (mode_ff == MODE_PDOWN) || (mode_ff == MODE_PSAVE);

	css_tick_count #(.W(CNT_W)) u_cnt (
		.clk_sys_i  (clk_sys_i),
		.reset_i    (reset_i),
		.load_i     (cnt_load),
		.load_val_i (cnt_val),
		.tick_i     (cnt_tick),
		.count_o    (cnt_q),
		.done_o     (cnt_done)
	);

	// ==========================================================
	// start-up sequencer
	always_comb begin
		nxt_state = state_ff;
		cnt_load = 1'b0;
		cnt_val = su_cyc;
		wr_take = 1'b0;
		unique case (state_ff)
			ST_FUSE: nxt_state = ST_LOAD_RST;
			ST_LOAD_RST: begin
				cnt_load = 1'b1;
				cnt_val = dly_cyc;
				nxt_state = ST_RST_DLY;
			end
			ST_RST_DLY: begin
				if (cnt_done) begin
					cnt_load = 1'b1;
					nxt_state = ST_SRC_START;
				end
			end
			ST_SRC_START: begin
				if (cnt_done) begin
					nxt_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (req_ff) begin
					wr_take = 1'b1;
					nxt_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_i && deep_mode) begin
					cnt_load = 1'b1;
					nxt_state = ST_SRC_START;
				end else if (wake_i) begin
					nxt_state = ST_RUN;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= ST_FUSE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// ==========================================================
	// clock domain gating
	always_comb begin
		nxt_core = (nxt_state == ST_RUN);
		nxt_periph = nxt_core ||
			(nxt_state == ST_SLEEP && mode_ff == MODE_IDLE);
		nxt_conv = nxt_periph ||
			(nxt_state == ST_SLEEP && mode_ff == MODE_ADCNR);
		// the real-time counter only stops in power-down
		nxt_async = async_en_ff &&
			!(nxt_state == ST_SLEEP && mode_ff == MODE_PDOWN);
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			core_ff <= 1'b0;
			periph_ff <= 1'b0;
			conv_ff <= 1'b0;
			async_ff <= 1'b0;
			full_ff <= 1'b0;
			range_ff <= 3'h0;
		end else begin
			core_ff <= nxt_core;
			periph_ff <= nxt_periph;
			conv_ff <= nxt_conv;
			async_ff <= nxt_async;
			full_ff <= dec_full;
			range_ff <= dec_range;
		end
	end

	assign core_clock_en_o = core_ff;
	assign program_memory_clock_en_o = core_ff;
	assign peripheral_clock_en_o = periph_ff;
	assign converter_clock_en_o = conv_ff;
	assign async_timer_clock_en_o = async_ff;
	assign full_swing_o = full_ff;
	assign xtal_range_o = range_ff;

	// ==========================================================
	// register slave
	always_comb begin
		nxt_wait = 1'b1;
		nxt_rdata = rdata_ff;
		nxt_mode = mode_ff;
		nxt_async_en = async_en_ff;
		// a new sleep request wins over the one being taken
		nxt_req = req_ff && !wr_take;
		if ((avs_read_i || avs_write_i) && wait_ff) begin
			nxt_wait = 1'b0;
			unique case (avs_address_i)
				REG_CTRL: nxt_rdata = {28'h0, async_en_ff, req_ff, mode_ff};
				REG_STATUS: nxt_rdata = {16'h0, state_ff, range_ff, swing_ff,
					sut_ff, sel_ff, dec_src};
				REG_COUNT: nxt_rdata = {{(32 - CNT_W){1'b0}}, cnt_q};
				default: nxt_rdata = 32'h0;
			endcase
		end
		if (avs_write_i && !wait_ff && avs_address_i == REG_CTRL &&
			avs_byteenable_i[0]) begin
			nxt_mode = avs_writedata_i[CTRL_MODE_LSB +: 2];
			nxt_async_en = avs_writedata_i[CTRL_ASYNC];
			if (avs_writedata_i[CTRL_SLEEP]) begin
				nxt_req = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			wait_ff <= 1'b1;
			rdata_ff <= 32'h0;
			mode_ff <= MODE_IDLE;
			req_ff <= 1'b0;
			async_en_ff <= 1'b0;
		end else begin
			wait_ff <= nxt_wait;
			rdata_ff <= nxt_rdata;
			mode_ff <= nxt_mode;
			req_ff <= nxt_req;
			async_en_ff <= nxt_async_en;
		end
	end

	assign avs_readdata_o = rdata_ff;
	assign avs_waitrequest_o = wait_ff;

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);

	sequence deep_wake_s;
		state_ff == ST_SLEEP && wake_i && deep_mode;
	endsequence
	sequence held_off_s;
		!core_clock_en_o && state_ff == ST_SRC_START;
	endsequence

	xtal_decode_a: assert property (sel_ff >= SEL_XTAL_MIN |->
		dec_src == SRC_XTAL) else $error("crystal codes not decoded");
	wide_range_a: assert property (dec_src == SRC_XTAL && !swing_ff |->
		dec_range == RNG_WIDE) else $error("full swing range wrong");
	long_delay_a: assert property (state_ff == ST_LOAD_RST &&
		dec_dly == DLY_LONG |=> cnt_q == CNT_W'(WDT_LONG_CYC))
		else $error("long reset delay count wrong");
	wdt_step_a: assert property (state_ff == ST_RST_DLY && !cnt_done &&
		wdt_tick_i |=> cnt_q + 1'b1 == $past(cnt_q))
		else $error("reset delay not on watchdog ticks");
	rst_order_a: assert property (state_ff == ST_RST_DLY &&
		cnt_done |=> state_ff == ST_SRC_START && cnt_q == $past(su_cyc))
		else $error("source count did not follow reset delay");
	deep_wake_a: assert property (deep_wake_s |=> held_off_s)
		else $error("deep wake skipped start-up count");
	flash_core_a: assert property (program_memory_clock_en_o ==
		core_clock_en_o) else $error("flash clock not with core clock");
	core_gate_a: assert property ($rose(core_clock_en_o) |->
		state_ff == ST_RUN && $past(state_ff) != ST_RST_DLY)
		else $error("core released out of sequence");
	adc_domain_a: assert property (state_ff == ST_SLEEP &&
		mode_ff == MODE_ADCNR |-> converter_clock_en_o &&
		!peripheral_clock_en_o && !core_clock_en_o)
		else $error("converter domain gating wrong");
	idle_gate_a: assert property (state_ff == ST_SLEEP &&
		mode_ff == MODE_IDLE |-> peripheral_clock_en_o && !core_clock_en_o)
		else $error("idle gating wrong");
	async_run_a: assert property (state_ff == ST_SLEEP &&
		mode_ff == MODE_PSAVE && async_en_ff |-> async_timer_clock_en_o)
		else $error("async timer stopped in power-save");

endmodule // css_clock_ctrl

// ---- tb/css_osc_model.sv ----
/*
 * Oscillator model: the selected source and the watchdog oscillator, each
 * giving one-cycle tick pulses at a divided rate of the system clock.
 * Assumes the bench sets the dividers; a divider of 1 ticks every cycle.
 */
`timescale 1ns/1ps
module css_osc_model (
	input  wire logic       clk_sys_i,
	input  wire logic       reset_i,
	input  wire logic [3:0] src_div_i,
	input  wire logic [3:0] wdt_div_i,
	output logic            src_tick_o,
	output logic            wdt_tick_o
);
	// ==========================================================
	// dividers; a slow divider models an oscillator still spinning up
	logic [3:0] src_cnt_ff;
	logic [3:0] wdt_cnt_ff;
	logic [3:0] nxt_src_cnt;
	logic [3:0] nxt_wdt_cnt;

	always_comb begin
		nxt_src_cnt = src_tick_o ? 4'h0 : src_cnt_ff + 4'h1;
		nxt_wdt_cnt = wdt_tick_o ? 4'h0 : wdt_cnt_ff + 4'h1;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			src_cnt_ff <= 4'h0;
			wdt_cnt_ff <= 4'h0;
		end else begin
			src_cnt_ff <= nxt_src_cnt;
			wdt_cnt_ff <= nxt_wdt_cnt;
		end
	end

	assign src_tick_o = (src_cnt_ff + 4'h1 >= src_div_i);
	assign wdt_tick_o = (wdt_cnt_ff + 4'h1 >= wdt_div_i);
endmodule // css_osc_model

// ---- tb/tb_clock_source_select_startup.sv ----
/*
 * Self-checking bench of the clock source select and start-up block.
 * Assumes the oscillator model of this folder and the design package.
 */
`timescale 1ns/1ps
module tb_clock_source_select_startup
	import css_pkg::*;
;
	localparam int C16 = 40;
	localparam int C32 = 50;
	localparam int WL  = 60;
	logic        clk_sys_i, reset_i, fuse_loaded_i, oscillator_swing_option_i;
	logic        src_tick_i, wdt_tick_i, wake_i, avs_read_i, avs_write_i;
	logic [3:0]  clock_source_select_i, avs_address_i, avs_byteenable_i;
	logic [3:0]  src_div, wdt_div;
	logic [1:0]  startup_time_select_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, rd;
	logic        avs_waitrequest_o, core_clock_en_o, peripheral_clock_en_o;
	logic        program_memory_clock_en_o, async_timer_clock_en_o;
	logic        converter_clock_en_o, full_swing_o;
	logic [2:0]  xtal_range_o;
	int          n_errors = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          t0 = 0;
	// rows: select, start-up, source cycles, watchdog cycles
	int tbl [17][4] = '{'{14,0,258,4096}, '{14,1,258,WL}, '{14,2,1024,0},
		'{14,3,1024,4096}, '{15,0,1024,WL}, '{15,1,C16,0}, '{15,2,C16,4096},
		'{15,3,C16,WL}, '{9,0,1024,4096}, '{9,1,1024,WL}, '{9,2,C32,WL},
		'{7,0,18,0}, '{7,1,18,4096}, '{7,2,18,WL}, '{7,3,6,4096},
		'{2,0,6,0}, '{0,0,6,0}};

	css_clock_ctrl #(.CK_16K_CYC(C16), .CK_32K_CYC(C32), .WDT_LONG_CYC(WL))
	u_dut (.clk_sys_i, .reset_i, .fuse_loaded_i, .clock_source_select_i,
		.startup_time_select_i, .oscillator_swing_option_i, .src_tick_i,
		.wdt_tick_i, .wake_i, .avs_address_i, .avs_read_i, .avs_write_i,
		.avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
		.avs_waitrequest_o, .core_clock_en_o, .peripheral_clock_en_o,
		.program_memory_clock_en_o, .async_timer_clock_en_o,
		.converter_clock_en_o, .full_swing_o, .xtal_range_o);
	css_osc_model u_osc (.clk_sys_i, .reset_i, .src_div_i(src_div),
		.wdt_div_i(wdt_div), .src_tick_o(src_tick_i), .wdt_tick_o(wdt_tick_i));

	// ==========================================================
	// clock, cycle count, common tasks
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) cyc <= cyc + 1;

	task automatic close_out;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, input logic [3:0] b);
		int k;
		k = 0;
		@(posedge clk_sys_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_byteenable_i <= b;
		avs_write_i <= w;
		avs_read_i <= ~w;
		do begin
			@(posedge clk_sys_i);
			k++;
		end while (avs_waitrequest_o !== 1'b0 && k < 64);
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		if (k >= 64) begin
			n_errors++;
			close_out();
		end
	endtask

	task automatic do_reset(input logic [3:0] s, input logic [1:0] u,
		input logic sw);
		@(posedge clk_sys_i);
		fuse_loaded_i <= 1'b1;
		clock_source_select_i <= s;
		startup_time_select_i <= u;
		oscillator_swing_option_i <= sw;
		reset_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t0 = cyc;
	endtask

	// cycles from t0 until the core clock is released must lie in lo..hi
	task automatic wait_core(input int lo, input int hi);
		while (core_clock_en_o !== 1'b1 && cyc - t0 <= hi)
			@(posedge clk_sys_i);
		tests_run++;
		if (cyc - t0 < lo || cyc - t0 > hi) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, cyc - t0, lo);
		end
		if (cyc - t0 > hi) close_out();
	endtask

	// program memory clock must track the core clock at all times
	always @(negedge clk_sys_i)
		if (!reset_i) chk({31'h0, program_memory_clock_en_o},
			{31'h0, core_clock_en_o});

	// ==========================================================
	// scenarios
	task automatic t_ship;
		repeat (20) @(posedge clk_sys_i);
		bus(1'b0, REG_STATUS, 32'h0, 4'hF);
		chk(rd, 32'h0000_430B);
		wait_core(192 - 4, 192 + 18);
		chk({full_swing_o, xtal_range_o}, 4'h0);
		chk({peripheral_clock_en_o, converter_clock_en_o,
			async_timer_clock_en_o}, 3'b110);
	endtask

	task automatic t_decode;
		logic [2:0] c, r;
		for (int sw = 0; sw < 2; sw++) begin
			for (int s = 0; s < 16; s++) begin
				c = s >= 10 ? 3'h0 : s == 9 ? 3'h1 : s >= 5 ? 3'h2
					: s >= 1 ? 3'h3 : 3'h4;
				r = s < 10 ? 3'h0 : sw == 0 ? 3'h4 : 3'(s / 2 - 4);
				do_reset(4'(s), 2'h0, 1'(sw));
				// range flop follows the captured fuses one edge later
				repeat (2) @(posedge clk_sys_i);
				bus(1'b0, REG_STATUS, 32'h0, 4'hF);
				chk(rd[12:0], {r, 1'(sw), 2'h0, 4'(s), c});
				@(negedge clk_sys_i);
				chk({full_swing_o, xtal_range_o}, {1'(~sw), r});
			end
		end
	endtask

	task automatic t_table;
		int n;
		// crystal rows keep select 111x, never the resonator-only range
		for (int i = 0; i < 17; i++) begin
			n = tbl[i][2] + tbl[i][3];
			do_reset(4'(tbl[i][0]), 2'(tbl[i][1]), 1'b1);
			wait_core(n, n + 12);
		end
	endtask

	task automatic t_sleep;
		logic [4:0] e [4] = '{5'b00111, 5'b00011, 5'b00000, 5'b00001};
		for (int m = 0; m < 4; m++) begin
			do_reset(4'h7, 2'h0, 1'b1);
			wait_core(18, 30);
			bus(1'b1, REG_CTRL, 32'h0000_000C | m, 4'h1);
			repeat (3) @(posedge clk_sys_i);
			@(negedge clk_sys_i);
			chk({core_clock_en_o, program_memory_clock_en_o,
				peripheral_clock_en_o, converter_clock_en_o,
				async_timer_clock_en_o}, e[m]);
			bus(1'b0, REG_STATUS, 32'h0, 4'hF);
			chk(rd[15:13], 3'h5);
			@(posedge clk_sys_i);
			t0 = cyc;
			wake_i <= 1'b1;
			@(posedge clk_sys_i);
			wake_i <= 1'b0;
			if (m < 2) wait_core(0, 4);
			else wait_core(18, 32);
			@(negedge clk_sys_i);
			chk(async_timer_clock_en_o, 1'b1);
		end
	endtask

	task automatic t_bus;
		logic [31:0] st;
		bus(1'b1, REG_CTRL, 32'h0000_0000, 4'hF);
		bus(1'b1, REG_CTRL, 32'h0000_000B, 4'h0);
		bus(1'b0, REG_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0);
		bus(1'b1, REG_CTRL, 32'h0000_000B, 4'hF);
		bus(1'b0, REG_CTRL, 32'h0, 4'hF);
		chk(rd, 32'h0000_000B);
		bus(1'b0, REG_STATUS, 32'h0, 4'hF);
		st = rd;
		bus(1'b1, REG_STATUS, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, REG_STATUS, 32'h0, 4'hF);
		chk(rd, st);
		bus(1'b1, 4'hC, 32'hFFFF_FFFF, 4'hF);
		bus(1'b0, 4'hC, 32'h0, 4'hF);
		chk(rd, 32'h0);
		wake_i <= 1'b1;
		@(posedge clk_sys_i);
		wake_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		chk(core_clock_en_o, 1'b1);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		reset_i = 1'b1;
		fuse_loaded_i = 1'b0;
		clock_source_select_i = 4'hF;
		startup_time_select_i = 2'h3;
		oscillator_swing_option_i = 1'b0;
		wake_i = 1'b0;
		avs_address_i = 4'h0;
		avs_read_i = 1'b0;
		avs_write_i = 1'b0;
		avs_writedata_i = 32'h0;
		avs_byteenable_i = 4'h0;
		src_div = 4'h2;
		wdt_div = 4'h3;
		repeat (12) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		t0 = cyc;
		t_ship();
		src_div <= 4'h1;
		wdt_div <= 4'h1;
		t_decode();
		t_table();
		t_sleep();
		t_bus();
		close_out();
	end
endmodule // tb_clock_source_select_startup
